// File: src/fmsr_pkg.sv
// Purpose: constants for the fault mask and status register bank
// Assumes: 100 MHz clk, 8-bit sub-addresses, 8 regulators
// Notes: global control has no printed sub-address; one is chosen here
package fmsr_pkg;
	localparam int unsigned NUM_REG          = 8;
	localparam logic [7:0]  ADDR_GLOBAL      = 8'h08;
	localparam logic [7:0]  ADDR_RST_MASK    = 8'h09;
	localparam logic [7:0]  ADDR_IRQ_MASK_A  = 8'h0A;
	localparam logic [7:0]  ADDR_IRQ_MASK_B  = 8'h0B;
	localparam logic [7:0]  ADDR_PG_STATUS   = 8'h0C;
	localparam logic [7:0]  ADDR_UV_STATUS   = 8'h0D;
	localparam logic [7:0]  ADDR_THERM       = 8'h0E;
	localparam logic [7:0]  RST_GLOBAL       = 8'h00;
	localparam logic [7:0]  RST_RST_MASK     = 8'hFF;
	localparam logic [7:0]  RST_IRQ_MASK     = 8'h00;
	localparam int unsigned BIT_POWER_CYCLE  = 7;
	localparam int unsigned BIT_LEVEL_HI     = 6;
	localparam int unsigned BIT_LEVEL_LO     = 5;
	localparam int unsigned BIT_IGNORE_EN    = 4;
	localparam int unsigned BIT_PULLDOWN     = 3;
	localparam int unsigned BIT_SLOW_EDGE    = 2;
	localparam int unsigned BIT_TEMP_ONCE    = 1;
	localparam int unsigned BIT_TEMP_CONT    = 0;
	localparam int unsigned BIT_OVERHEAT     = 7;
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned POWER_CYCLE_MS   = 1000;
	localparam int unsigned POWER_CYCLE_CYC  = CLK_HZ / 1000 * POWER_CYCLE_MS;
	localparam int unsigned TEMP_PERIOD_US   = 2000;
	localparam int unsigned TEMP_PERIOD_CYC  = CLK_HZ / 1000000
		* TEMP_PERIOD_US;
	localparam int unsigned CNT_W            = 27;
endpackage

// File: src/fmsr_regs.sv
// Purpose: control, fault-mask and fault-status registers of a
//          multichannel step-down regulator controller
// Assumes: serial host front end gives read/write strobes and an 8-bit sub-address, decoded here;
//          analog monitors arrive asynchronous and are synchronised
// Notes: the temperature converter reports through temp_done/temp_code
`timescale 1ns/1ps

// Functional notes
// - global control register resets to zero.
// - reset mask at 09h, bit n-1 per regulator n, routes power-good fault.
// - reset mask powers up as FFh.
// - interrupt masks at 0Ah and 0Bh share layout, reset to zero.
// - low reset or interrupt output means a fault happened.
// - status 0Ch reports power-good fault state of regulators 1..8.
// - status 0Dh reports input undervoltage state of regulators 1..8.
// - status latched at interrupt; masked bits read live value.
// - 0Eh holds latched overheat flag at bit 7 above 7-bit temperature.
// - overheat flag ignores all masks and always reports.
// - clear command empties latched status contents.
// - power-good bit reads 0 when output is over 7.5% low.
// - undervoltage bit reads 0 while input is above threshold.
// - writes to the three status registers are ignored.
// - global bit 7 shuts converters down 1 s, then self-clears.
// - global bits 6:5 select overheat alarm level, default 00.
// - global bit 4 makes the device disregard the enable pins.
// - global bit 3 selects switch-node pulldown in shutdown.
// - global bit 2 selects slower switch-node slew.
// - global bit 1 starts one conversion, self-clears on completion.
// - global bit 0 samples temperature continuously, every 2 ms.
module fmsr_regs #(
	parameter int unsigned POWER_CYCLE_CYC = fmsr_pkg::POWER_CYCLE_CYC,
	parameter int unsigned TEMP_PERIOD_CYC = fmsr_pkg::TEMP_PERIOD_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       clear_latched_faults,
	input  wire logic [7:0] output_regulation_ok,
	input  wire logic [7:0] input_undervoltage_flag,
	input  wire logic       overheat_flag,
	input  wire logic       temp_done,
	input  wire logic [6:0] temp_code,
	input  wire logic [7:0] enable_pins,
	output logic      [7:0] rd_data,
	output logic            rst_out_n,
	output logic            irq_out_n,
	output logic      [7:0] converter_enable,
	output logic      [1:0] overheat_level,
	output logic            shutdown_node_pulldown,
	output logic            slow_edge,
	output logic            temp_start
);
	logic [7:0] pg_s1_ff, pg_s2_ff, uv_s1_ff, uv_s2_ff, en_s1_ff, en_s2_ff;
	logic       ot_s1_ff, ot_s2_ff;
	logic [7:0] global_ff, rst_mask_ff, irq_mask_a_ff, irq_mask_b_ff;
	logic [7:0] pg_lat_ff, uv_lat_ff;
	logic       ot_lat_ff;
	logic [6:0] temp_ff;
	logic [fmsr_pkg::CNT_W-1:0] pc_cnt_ff, tp_cnt_ff;
	logic       busy_ff;
	logic [7:0] rd_data_ff;
	logic       rst_n_ff, irq_n_ff, start_ff;
	logic [7:0] conv_en_ff;
	logic [1:0] lvl_ff;
	logic       pd_ff, slow_ff;

	// fault is active when power-good is low or undervoltage flag is high
	wire  [7:0] pg_fault = ~pg_s2_ff;
	wire  [7:0] uv_fault = uv_s2_ff;
	wire        wr_glob  = wr_en && addr == fmsr_pkg::ADDR_GLOBAL;
	wire        wr_rstm  = wr_en && addr == fmsr_pkg::ADDR_RST_MASK;
	wire        wr_irqa  = wr_en && addr == fmsr_pkg::ADDR_IRQ_MASK_A;
	wire        wr_irqb  = wr_en && addr == fmsr_pkg::ADDR_IRQ_MASK_B;
	wire  [7:0] pg_set   = pg_fault & irq_mask_a_ff;
	wire  [7:0] uv_set   = uv_fault & irq_mask_b_ff;
	wire        pc_done  = global_ff[fmsr_pkg::BIT_POWER_CYCLE]
		&& pc_cnt_ff == fmsr_pkg::CNT_W'(POWER_CYCLE_CYC - 1);
	wire        tp_tick  = global_ff[fmsr_pkg::BIT_TEMP_CONT]
		&& tp_cnt_ff == fmsr_pkg::CNT_W'(TEMP_PERIOD_CYC - 1);
	wire        once_req = global_ff[fmsr_pkg::BIT_TEMP_ONCE] && !busy_ff;
	wire        start_req = (once_req || tp_tick) && !busy_ff;

	// latched bits read the latch, masked bits read live state
	wire  [7:0] pg_view  = (irq_mask_a_ff & ~pg_lat_ff)
		| (~irq_mask_a_ff & pg_s2_ff);
	wire  [7:0] uv_view  = (irq_mask_b_ff & uv_lat_ff)
		| (~irq_mask_b_ff & uv_s2_ff);
	wire  [7:0] nxt_rd_data =
		addr == fmsr_pkg::ADDR_GLOBAL     ? global_ff :
		addr == fmsr_pkg::ADDR_RST_MASK   ? rst_mask_ff :
		addr == fmsr_pkg::ADDR_IRQ_MASK_A ? irq_mask_a_ff :
		addr == fmsr_pkg::ADDR_IRQ_MASK_B ? irq_mask_b_ff :
		addr == fmsr_pkg::ADDR_PG_STATUS  ? pg_view :
		addr == fmsr_pkg::ADDR_UV_STATUS  ? uv_view :
		addr == fmsr_pkg::ADDR_THERM      ? {ot_lat_ff, temp_ff} :
		8'h00;
	wire        nxt_irq_n = !(|pg_lat_ff || |uv_lat_ff
		|| ot_lat_ff);
	wire        nxt_rst_n = !(|(pg_fault & rst_mask_ff));
	wire  [7:0] nxt_conv_en =
		global_ff[fmsr_pkg::BIT_POWER_CYCLE] ? 8'h00 :
		global_ff[fmsr_pkg::BIT_IGNORE_EN]   ? 8'h00 :
		en_s2_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pg_s1_ff <= 8'hFF;
			pg_s2_ff <= 8'hFF;
			uv_s1_ff <= 8'h00;
			uv_s2_ff <= 8'h00;
			en_s1_ff <= 8'h00;
			en_s2_ff <= 8'h00;
			ot_s1_ff <= 1'b0;
			ot_s2_ff <= 1'b0;
		end else begin
			pg_s1_ff <= output_regulation_ok;
			pg_s2_ff <= pg_s1_ff;
			uv_s1_ff <= input_undervoltage_flag;
			uv_s2_ff <= uv_s1_ff;
			en_s1_ff <= enable_pins;
			en_s2_ff <= en_s1_ff;
			ot_s1_ff <= overheat_flag;
			ot_s2_ff <= ot_s1_ff;
		end
	end

	// masks; status addresses have no write decode at all
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_mask_ff   <= fmsr_pkg::RST_RST_MASK;
			irq_mask_a_ff <= fmsr_pkg::RST_IRQ_MASK;
			irq_mask_b_ff <= fmsr_pkg::RST_IRQ_MASK;
		end else begin
			if (wr_rstm) rst_mask_ff <= wr_data;
			if (wr_irqa) irq_mask_a_ff <= wr_data;
			if (wr_irqb) irq_mask_b_ff <= wr_data;
		end
	end

	// global control; self-clearing bits drop when their job completes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			global_ff <= fmsr_pkg::RST_GLOBAL;
		end else if (wr_glob) begin
			global_ff <= wr_data;
		end else begin
			if (pc_done) global_ff[fmsr_pkg::BIT_POWER_CYCLE] <= 1'b0;
			if (temp_done && busy_ff)
				global_ff[fmsr_pkg::BIT_TEMP_ONCE] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc_cnt_ff <= '0;
		end else if (global_ff[fmsr_pkg::BIT_POWER_CYCLE] && !pc_done) begin
			pc_cnt_ff <= pc_cnt_ff + 1'b1;
		end else begin
			pc_cnt_ff <= '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tp_cnt_ff <= '0;
		end else if (global_ff[fmsr_pkg::BIT_TEMP_CONT] && !tp_tick) begin
			tp_cnt_ff <= tp_cnt_ff + 1'b1;
		end else begin
			tp_cnt_ff <= '0;
		end
	end

	// one conversion in flight at a time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_ff  <= 1'b0;
			start_ff <= 1'b0;
			temp_ff  <= 7'h00;
		end else begin
			start_ff <= start_req;
			if (start_req) busy_ff <= 1'b1;
			else if (temp_done) busy_ff <= 1'b0;
			if (temp_done) temp_ff <= temp_code;
		end
	end

	// set wins over clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pg_lat_ff <= 8'h00;
			uv_lat_ff <= 8'h00;
			ot_lat_ff <= 1'b0;
		end else begin
			pg_lat_ff <= (clear_latched_faults ? 8'h00 : pg_lat_ff)
				| pg_set;
			uv_lat_ff <= (clear_latched_faults ? 8'h00 : uv_lat_ff)
				| uv_set;
			ot_lat_ff <= (clear_latched_faults ? 1'b0 : ot_lat_ff)
				| ot_s2_ff;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_ff <= 8'h00;
			rst_n_ff   <= 1'b1;
			irq_n_ff   <= 1'b1;
			conv_en_ff <= 8'h00;
			lvl_ff     <= 2'b00;
			pd_ff      <= 1'b0;
			slow_ff    <= 1'b0;
		end else begin
			if (rd_en) rd_data_ff <= nxt_rd_data;
			rst_n_ff   <= nxt_rst_n;
			irq_n_ff   <= nxt_irq_n;
			conv_en_ff <= nxt_conv_en;
			lvl_ff     <= global_ff[fmsr_pkg::BIT_LEVEL_HI:
				fmsr_pkg::BIT_LEVEL_LO];
			pd_ff      <= global_ff[fmsr_pkg::BIT_PULLDOWN];
			slow_ff    <= global_ff[fmsr_pkg::BIT_SLOW_EDGE];
		end
	end

	assign rd_data                = rd_data_ff;
	assign rst_out_n              = rst_n_ff;
	assign irq_out_n              = irq_n_ff;
	assign converter_enable       = conv_en_ff;
	assign overheat_level         = lvl_ff;
	assign shutdown_node_pulldown = pd_ff;
	assign slow_edge              = slow_ff;
	assign temp_start             = start_ff;

	property p_rst_mask_reset;
		@(posedge clk)
		$rose(nrst) |-> rst_mask_ff == fmsr_pkg::RST_RST_MASK;
	endproperty
	a_rst_mask_reset: assert property (p_rst_mask_reset)
		else $error("reset mask not FFh after reset");

	property p_rst_route;
		@(posedge clk) disable iff (!nrst)
		|(pg_fault & rst_mask_ff) |=> !rst_out_n;
	endproperty
	a_rst_route: assert property (p_rst_route)
		else $error("masked power-good fault did not pull reset low");

	property p_status_no_write;
		@(posedge clk) disable iff (!nrst)
		wr_en && addr >= fmsr_pkg::ADDR_PG_STATUS
		&& addr <= fmsr_pkg::ADDR_THERM |=> $stable(rst_mask_ff)
		&& $stable(irq_mask_a_ff) && $stable(irq_mask_b_ff);
	endproperty
	a_status_no_write: assert property (p_status_no_write)
		else $error("status write changed a register");

	property p_clear;
		@(posedge clk) disable iff (!nrst)
		clear_latched_faults && pg_set == 8'h00 |=> pg_lat_ff == 8'h00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not empty power-good latch");

	property p_latch_set;
		@(posedge clk) disable iff (!nrst)
		|pg_set |=> ##1 !irq_out_n;
	endproperty
	a_latch_set: assert property (p_latch_set)
		else $error("enabled fault did not assert interrupt");

	property p_overheat;
		@(posedge clk) disable iff (!nrst)
		ot_s2_ff |=> ot_lat_ff ##1 !irq_out_n;
	endproperty
	a_overheat: assert property (p_overheat)
		else $error("overheat did not latch or interrupt");

	sequence s_pc_start;
		wr_glob && wr_data[fmsr_pkg::BIT_POWER_CYCLE];
	endsequence
	property p_pc_off;
		@(posedge clk) disable iff (!nrst)
		s_pc_start |=> ##1 converter_enable == 8'h00;
	endproperty
	a_pc_off: assert property (p_pc_off)
		else $error("power cycle did not shut converters");

	property p_temp_once;
		@(posedge clk) disable iff (!nrst)
		busy_ff && temp_done && !wr_glob
		|=> !global_ff[fmsr_pkg::BIT_TEMP_ONCE];
	endproperty
	a_temp_once: assert property (p_temp_once)
		else $error("one-shot temperature bit not cleared");

	property p_global_reset;
		@(posedge clk)
		$rose(nrst) |-> global_ff == fmsr_pkg::RST_GLOBAL;
	endproperty
	a_global_reset: assert property (p_global_reset)
		else $error("global control not zero after reset");

	property p_irq_mask_reset;
		@(posedge clk)
		$rose(nrst) |-> irq_mask_a_ff == fmsr_pkg::RST_IRQ_MASK
		&& irq_mask_b_ff == fmsr_pkg::RST_IRQ_MASK;
	endproperty
	a_irq_mask_reset: assert property (p_irq_mask_reset)
		else $error("interrupt masks not zero after reset");

	property p_set_wins;
		@(posedge clk) disable iff (!nrst)
		clear_latched_faults && |pg_set |=>
		(pg_lat_ff & $past(pg_set)) == $past(pg_set);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear dropped a fault that was being set");

	property p_rst_release;
		@(posedge clk) disable iff (!nrst)
		!(|(pg_fault & rst_mask_ff)) |=> rst_out_n;
	endproperty
	a_rst_release: assert property (p_rst_release)
		else $error("reset output held without a masked fault");

	sequence s_irq_held;
		!irq_out_n ##1 !irq_out_n;
	endsequence
	property p_irq_hold;
		@(posedge clk) disable iff (!nrst)
		(|pg_lat_ff || |uv_lat_ff || ot_lat_ff) && !clear_latched_faults
		|=> s_irq_held;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt released before clear");

	property p_clear_release;
		@(posedge clk) disable iff (!nrst)
		clear_latched_faults && !(|pg_set) && !(|uv_set) && !ot_s2_ff
		|=> ##1 irq_out_n;
	endproperty
	a_clear_release: assert property (p_clear_release)
		else $error("interrupt not released after clear");

	property p_rst_mask_write;
		@(posedge clk) disable iff (!nrst)
		wr_rstm |=> rst_mask_ff == $past(wr_data);
	endproperty
	a_rst_mask_write: assert property (p_rst_mask_write)
		else $error("reset mask write lost");

	property p_pc_release;
		@(posedge clk) disable iff (!nrst)
		pc_done && !wr_glob |=> !global_ff[fmsr_pkg::BIT_POWER_CYCLE];
	endproperty
	a_pc_release: assert property (p_pc_release)
		else $error("power cycle bit did not clear at end of count");

	property p_pc_hold;
		@(posedge clk) disable iff (!nrst)
		global_ff[fmsr_pkg::BIT_POWER_CYCLE] && !pc_done && !wr_glob
		|=> global_ff[fmsr_pkg::BIT_POWER_CYCLE];
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("power cycle bit cleared early");

	property p_temp_start;
		@(posedge clk) disable iff (!nrst)
		once_req |=> temp_start;
	endproperty
	a_temp_start: assert property (p_temp_start)
		else $error("one-shot request did not start a conversion");

	property p_temp_pulse;
		@(posedge clk) disable iff (!nrst)
		temp_start |=> !temp_start;
	endproperty
	a_temp_pulse: assert property (p_temp_pulse)
		else $error("conversion start longer than one cycle");

	property p_uv_latch;
		@(posedge clk) disable iff (!nrst)
		|uv_set |=> (uv_lat_ff & $past(uv_set)) == $past(uv_set);
	endproperty
	a_uv_latch: assert property (p_uv_latch)
		else $error("enabled undervoltage fault not latched");
endmodule

// File: sim/fmsr_host.sv
// Purpose: host side of the sub-address register access
// Assumes: requests move 1 ns after the rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
module fmsr_host (
	input  wire logic       clk,
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] addr,
	output logic      [7:0] wr_data,
	output logic            clear_latched_faults,
	input  wire logic [7:0] rd_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		clear_latched_faults = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		wr_en = 1'b1;
		addr = a;
		wr_data = d;
		@(posedge clk) #1;
		wr_en = 1'b0;
		addr = ~a;
		wr_data = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		rd_en = 1'b1;
		addr = a;
		@(posedge clk) #1;
		rd_en = 1'b0;
		addr = ~a;
		d = rd_data;
	endtask
	task automatic clr();
		@(posedge clk) #1;
		clear_latched_faults = 1'b1;
		@(posedge clk) #1;
		clear_latched_faults = 1'b0;
	endtask
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench of the fault mask and status registers
// Assumes: short power-cycle and sampling counts set below
// Notes: monitor inputs are given 6 cycles to pass the synchronisers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       wr_en, rd_en, clr, oh = 1'b0, tdn = 1'b0;
	logic [7:0] addr, wr_data, rd_data, conv, pg = 8'hFF, uv = 8'h00;
	logic [7:0] en = 8'hFF;
	logic [6:0] tcode = 7'h00;
	logic       rst_n, irq_n, pd, slow, tstart;
	logic [1:0] lvl;
	int         err_count = 0, n_tests = 0, n_start = 0;
	always #5 clk = ~clk;
	always @(posedge clk) if (tstart === 1'b1) n_start++;
	fmsr_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .clear_latched_faults(clr), .rd_data(rd_data));
	fmsr_regs #(.POWER_CYCLE_CYC(50), .TEMP_PERIOD_CYC(20)) dut_u (
		.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .clear_latched_faults(clr),
		.output_regulation_ok(pg), .input_undervoltage_flag(uv),
		.overheat_flag(oh), .temp_done(tdn), .temp_code(tcode),
		.enable_pins(en), .rd_data(rd_data), .rst_out_n(rst_n),
		.irq_out_n(irq_n), .converter_enable(conv), .overheat_level(lvl),
		.shutdown_node_pulldown(pd), .slow_edge(slow), .temp_start(tstart));
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic crd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		`CHK($sformatf("reg %h", a), e, d)
	endtask
	task automatic pulse_done();
		@(posedge clk) #1;
		tdn = 1'b1;
		@(posedge clk) #1;
		tdn = 1'b0;
	endtask
	initial begin
		w(20000);
		err_count++;
		print_verdict();
	end
	initial begin
		w(3);
		nrst = 1'b1;
		crd(8'h08, 8'h00);
		crd(8'h09, 8'hFF);
		crd(8'h0A, 8'h00);
		crd(8'h0B, 8'h00);
		crd(8'h20, 8'h00);
		for (int a = 9; a < 12; a++) begin
			host_u.wr(8'(a), 8'(a) ^ 8'h5A);
			crd(8'(a), 8'(a) ^ 8'h5A);
		end
		host_u.wr(8'h09, 8'h01);
		host_u.wr(8'h0A, 8'h01);
		host_u.wr(8'h0B, 8'h00);
		pg = 8'hFD;
		w(6);
		`CHK("rst_n", 1'b1, rst_n)
		`CHK("irq_n", 1'b1, irq_n)
		crd(8'h0C, 8'hFD);
		pg = 8'hFE;
		w(6);
		`CHK("rst_n", 1'b0, rst_n)
		`CHK("irq_n", 1'b0, irq_n)
		host_u.clr();
		w(3);
		`CHK("irq_n", 1'b0, irq_n)
		pg = 8'hFF;
		w(6);
		`CHK("rst_n", 1'b1, rst_n)
		`CHK("irq_n", 1'b0, irq_n)
		crd(8'h0C, 8'hFE);
		host_u.wr(8'h0C, 8'h00);
		crd(8'h0C, 8'hFE);
		host_u.clr();
		w(3);
		`CHK("irq_n", 1'b1, irq_n)
		crd(8'h0C, 8'hFF);
		host_u.wr(8'h0B, 8'h80);
		uv = 8'h80;
		w(6);
		`CHK("irq_n", 1'b0, irq_n)
		uv = 8'h01;
		w(6);
		crd(8'h0D, 8'h81);
		host_u.wr(8'h0D, 8'h00);
		crd(8'h0D, 8'h81);
		uv = 8'h00;
		host_u.clr();
		w(6);
		crd(8'h0D, 8'h00);
		host_u.wr(8'h0A, 8'h00);
		host_u.wr(8'h0B, 8'h00);
		oh = 1'b1;
		w(6);
		`CHK("irq_n", 1'b0, irq_n)
		oh = 1'b0;
		tcode = 7'h35;
		pulse_done();
		w(6);
		crd(8'h0E, 8'hB5);
		host_u.wr(8'h0E, 8'h00);
		crd(8'h0E, 8'hB5);
		host_u.clr();
		w(3);
		`CHK("irq_n", 1'b1, irq_n)
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h08, 8'(i << 5) | 8'h0C);
			w(2);
			`CHK("level", 2'(i), lvl)
			`CHK("pulldown", 1'b1, pd)
			`CHK("slow", 1'b1, slow)
		end
		crd(8'h08, 8'h6C);
		en = 8'hA5;
		host_u.wr(8'h08, 8'h00);
		w(6);
		`CHK("conv", 8'hA5, conv)
		`CHK("pulldown", 1'b0, pd)
		`CHK("slow", 1'b0, slow)
		host_u.wr(8'h08, 8'h10);
		w(3);
		`CHK("conv", 8'h00, conv)
		host_u.wr(8'h08, 8'h80);
		w(3);
		`CHK("conv", 8'h00, conv)
		crd(8'h08, 8'h80);
		w(43);
		crd(8'h08, 8'h80);
		crd(8'h08, 8'h00);
		w(3);
		`CHK("conv", 8'hA5, conv)
		n_start = 0;
		host_u.wr(8'h08, 8'h02);
		w(3);
		crd(8'h08, 8'h02);
		`CHK("starts", 1, n_start)
		pulse_done();
		w(2);
		crd(8'h08, 8'h00);
		n_start = 0;
		host_u.wr(8'h08, 8'h01);
		repeat (100) begin
			w(1);
			if (tstart === 1'b1) pulse_done();
		end
		`CHK("cont", 1'b1, n_start inside {[4:6]})
		nrst = 1'b0;
		w(3);
		nrst = 1'b1;
		crd(8'h08, 8'h00);
		crd(8'h09, 8'hFF);
		print_verdict();
	end
endmodule
